/* File: rtl/rscpu_regs.svh */
// Constants for the reset source and CPU reset state block.
// Assumes a single 200 MHz clock; included by bare name.
`ifndef RSCPU_REGS_SVH
`define RSCPU_REGS_SVH

// Reset-cause status bit positions and power-on cause value
`define RSCPU_BIT_POR      7
`define RSCPU_BIT_PIN      6
`define RSCPU_BIT_WDOG     5
`define RSCPU_BIT_ILLEGAL_OPCODE_FLAG     4
`define RSCPU_BIT_ILAD     3
`define RSCPU_CAUSE_POR    8'h80

// CPU register reset values and reset vector addresses
`define RSCPU_SP_RST       16'h00FF
`define RSCPU_HX_HI_RST    8'h00
`define RSCPU_CCR_RST      8'h68
`define RSCPU_VEC_HI_ADDR  16'hFFFE
`define RSCPU_VEC_LO_ADDR  16'hFFFF

// Timing
`define RSCPU_CLK_PERIOD_NS 5
`define RSCPU_RST_HOLD_NS   100
`define RSCPU_RST_HOLD_CYC  ((`RSCPU_RST_HOLD_NS + `RSCPU_CLK_PERIOD_NS - 1) / `RSCPU_CLK_PERIOD_NS)
`define RSCPU_XTAL_STAB_CYC 4096
`define RSCPU_FLASH_MIN_HZ  1000000

`endif

/* File: rtl/rscpu_pkg.sv */
// Types for the reset source and CPU reset state block.
// Assumes nothing of its surroundings.
package rscpu_pkg;

    typedef enum logic [8:0] {
        ST_VEC_HI   = 9'h001,
        ST_VEC_LO   = 9'h002,
        ST_VEC_DONE = 9'h004,
        ST_RUN      = 9'h008,
        ST_PUSH_LO  = 9'h010,
        ST_PUSH_HI  = 9'h020,
        ST_POP_HI   = 9'h040,
        ST_POP_LO   = 9'h080,
        ST_POP_DONE = 9'h100
    } rscpu_state_e;

endpackage : rscpu_pkg

/* File: rtl/rscpu_reset.sv */
// Reset sources, cause flags, clock source lock and CPU reset state.
// Assumes CPU events arrive on ref_clk_in; memory answers a read next cycle.
`include "rscpu_regs.svh"

module rscpu_reset
    import rscpu_pkg::*;
#(
    parameter int XTAL_STAB_CYC = `RSCPU_XTAL_STAB_CYC,
    parameter int BUS_HZ_IRC    = 1000000,
    parameter int BUS_HZ_XTAL   = 8192
) (
    // Clock and reset
    input  wire logic        ref_clk_in,
    input  wire logic        arst_n_in,
    // Reset sources
    input  wire logic        illegal_opcode_in,
    input  wire logic        illegal_addr_in,
    input  wire logic        watchdog_timeout_in,
    input  wire logic        ext_reset_n_in,
    input  wire logic        stop_instr_in,
    input  wire logic        stop_enable_in,
    // Clock source
    input  wire logic        clk_sel_wr_in,
    input  wire logic        clk_sel_xtal_in,
    input  wire logic        xtal_clk_in,
    input  wire logic        flash_prog_req_in,
    // Instruction events
    input  wire logic        call_subroutine_instr_in,
    input  wire logic        return_instr_in,
    input  wire logic [15:0] ret_addr_in,
    input  wire logic [15:0] target_in,
    // Memory port
    input  wire logic [7:0]  mem_rdata_in,
    output logic      [15:0] mem_addr_out,
    output logic      [7:0]  mem_wdata_out,
    output logic             mem_re_out,
    output logic             mem_we_out,
    // Status and reset outputs
    output logic      [7:0]  reset_cause_status_out,
    output logic             sys_reset_out,
    output logic             periph_reset_out,
    output logic             stop_mode_out,
    output logic             bus_clk_sel_out,
    output logic             clk_sel_locked_out,
    output logic             flash_prog_en_out,
    // CPU state
    output logic      [15:0] pc_out,
    output logic      [15:0] sp_out,
    output logic      [7:0]  index_hi_out,
    output logic      [7:0]  ccr_out,
    output logic             cpu_run_out,
    output logic             busy_out
);

    // Settle counter is 13 bits wide; bus rates must be positive
    if (XTAL_STAB_CYC < 1 || XTAL_STAB_CYC > 8191 || BUS_HZ_IRC < 1 || BUS_HZ_XTAL < 1) begin : g_param_check
        $error("rscpu_reset: unsupported parameter value");
    end

    localparam logic [12:0] STAB_MAX = 13'(XTAL_STAB_CYC);
    localparam logic [7:0]  HOLD_CYC = 8'(`RSCPU_RST_HOLD_CYC);

    ////////////////////////////////////////////////////////////////////////////
    // Pin synchronisers
    logic [1:0] pin_sync_r;
    logic [2:0] xtal_sync_r;
    logic [1:0] pin_sync_nxt;
    logic [2:0] xtal_sync_nxt;
    logic       pin_low;
    logic       xtal_edge;

    always_comb begin
        pin_sync_nxt  = {pin_sync_r[0], ext_reset_n_in};
        xtal_sync_nxt = {xtal_sync_r[1:0], xtal_clk_in};
    end

    always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            pin_sync_r  <= 2'h3;
            xtal_sync_r <= 3'h0;
        end else begin
            pin_sync_r  <= pin_sync_nxt;
            xtal_sync_r <= xtal_sync_nxt;
        end
    end

    assign pin_low   = ~pin_sync_r[1];
    assign xtal_edge = xtal_sync_r[1] & ~xtal_sync_r[2];

    ////////////////////////////////////////////////////////////////////////////
    // Reset generation and cause capture
    logic [7:0]   rst_cnt_r;
    logic [7:0]   cause_r;
    logic [7:0]   rst_cnt_nxt;
    logic [7:0]   cause_nxt;
    logic [7:0]   src_vec;
    logic         illegal_opcode_flag_evt;
    logic         rst_hold;
    logic         trig;
    rscpu_state_e state_r;

    always_comb begin
        illegal_opcode_flag_evt = illegal_opcode_in | (stop_instr_in & ~stop_enable_in & cpu_run_out);
        src_vec  = 8'h00;
        src_vec[`RSCPU_BIT_PIN]  = pin_low;
        src_vec[`RSCPU_BIT_WDOG] = watchdog_timeout_in;
        src_vec[`RSCPU_BIT_ILLEGAL_OPCODE_FLAG] = illegal_opcode_flag_evt;
        src_vec[`RSCPU_BIT_ILAD] = illegal_addr_in;
        trig        = |src_vec;
        rst_cnt_nxt = trig ? HOLD_CYC : (rst_cnt_r != 8'h00 ? rst_cnt_r - 8'h01 : 8'h00);
        cause_nxt   = trig ? src_vec : cause_r;
    end

    always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            rst_cnt_r <= HOLD_CYC;
            cause_r   <= `RSCPU_CAUSE_POR;
        end else begin
            rst_cnt_r <= rst_cnt_nxt;
            cause_r   <= cause_nxt;
        end
    end

    assign rst_hold               = rst_cnt_r != 8'h00;
    assign sys_reset_out          = rst_hold;
    assign periph_reset_out       = rst_hold;
    assign reset_cause_status_out = cause_r;
    assign stop_mode_out          = stop_instr_in & stop_enable_in & cpu_run_out;

    ////////////////////////////////////////////////////////////////////////////
    // Clock source select, crystal settling
    logic        lock_r;
    logic        xtal_req_r;
    logic        xtal_sel_r;
    logic [12:0] stab_cnt_r;
    logic        lock_nxt;
    logic        xtal_req_nxt;
    logic        xtal_sel_nxt;
    logic [12:0] stab_cnt_nxt;

    always_comb begin
        lock_nxt     = lock_r;
        xtal_req_nxt = xtal_req_r;
        stab_cnt_nxt = stab_cnt_r;
        if (rst_hold) begin
            lock_nxt     = 1'b0;
            xtal_req_nxt = 1'b0;
            stab_cnt_nxt = 13'h0000;
        end else begin
            if (clk_sel_wr_in && !lock_r) begin
                lock_nxt     = 1'b1;
                xtal_req_nxt = clk_sel_xtal_in;
            end
            if (xtal_req_r && xtal_edge && stab_cnt_r != STAB_MAX) begin
                stab_cnt_nxt = stab_cnt_r + 13'h0001;
            end
        end
        xtal_sel_nxt = !rst_hold && xtal_req_r && stab_cnt_r == STAB_MAX;
    end

    always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            lock_r     <= 1'b0;
            xtal_req_r <= 1'b0;
            xtal_sel_r <= 1'b0;
            stab_cnt_r <= 13'h0000;
        end else begin
            lock_r     <= lock_nxt;
            xtal_req_r <= xtal_req_nxt;
            xtal_sel_r <= xtal_sel_nxt;
            stab_cnt_r <= stab_cnt_nxt;
        end
    end

    assign bus_clk_sel_out    = xtal_sel_r;
    assign clk_sel_locked_out = lock_r;
    assign flash_prog_en_out  = flash_prog_req_in && !rst_hold &&
                                (xtal_sel_r ? BUS_HZ_XTAL : BUS_HZ_IRC) >= `RSCPU_FLASH_MIN_HZ;

    ////////////////////////////////////////////////////////////////////////////
    // Vector fetch, call and return sequencing
    rscpu_state_e state_nxt;
    logic [15:0]  pc_r;
    logic [15:0]  sp_r;
    logic [15:0]  ret_r;
    logic [15:0]  target_r;
    logic [15:0]  pc_nxt;
    logic [15:0]  sp_nxt;
    logic [15:0]  ret_nxt;
    logic [15:0]  target_nxt;

    always_comb begin
        state_nxt     = state_r;
        pc_nxt        = pc_r;
        sp_nxt        = sp_r;
        ret_nxt       = ret_r;
        target_nxt    = target_r;
        mem_addr_out  = 16'h0000;
        mem_wdata_out = 8'h00;
        mem_re_out    = 1'b0;
        mem_we_out    = 1'b0;
        unique case (state_r)
            ST_VEC_HI: begin
                mem_addr_out = `RSCPU_VEC_HI_ADDR;
                mem_re_out   = 1'b1;
                state_nxt    = ST_VEC_LO;
            end
            ST_VEC_LO: begin
                mem_addr_out = `RSCPU_VEC_LO_ADDR;
                mem_re_out   = 1'b1;
                pc_nxt       = {mem_rdata_in, 8'h00};
                state_nxt    = ST_VEC_DONE;
            end
            ST_VEC_DONE: begin
                pc_nxt    = {pc_r[15:8], mem_rdata_in};
                state_nxt = ST_RUN;
            end
            ST_RUN: begin
                if (call_subroutine_instr_in) begin
                    ret_nxt    = ret_addr_in;
                    target_nxt = target_in;
                    state_nxt  = ST_PUSH_LO;
                end else if (return_instr_in) begin
                    state_nxt = ST_POP_HI;
                end
            end
            ST_PUSH_LO: begin
                mem_addr_out  = sp_r;
                mem_wdata_out = ret_r[7:0];
                mem_we_out    = 1'b1;
                sp_nxt        = sp_r - 16'h0001;
                state_nxt     = ST_PUSH_HI;
            end
            ST_PUSH_HI: begin
                mem_addr_out  = sp_r;
                mem_wdata_out = ret_r[15:8];
                mem_we_out    = 1'b1;
                sp_nxt        = sp_r - 16'h0001;
                pc_nxt        = target_r;
                state_nxt     = ST_RUN;
            end
            ST_POP_HI: begin
                mem_addr_out = sp_r + 16'h0001;
                mem_re_out   = 1'b1;
                sp_nxt       = sp_r + 16'h0001;
                state_nxt    = ST_POP_LO;
            end
            ST_POP_LO: begin
                mem_addr_out = sp_r + 16'h0001;
                mem_re_out   = 1'b1;
                sp_nxt       = sp_r + 16'h0001;
                pc_nxt       = {mem_rdata_in, pc_r[7:0]};
                state_nxt    = ST_POP_DONE;
            end
            ST_POP_DONE: begin
                pc_nxt    = {pc_r[15:8], mem_rdata_in};
                state_nxt = ST_RUN;
            end
            default: begin
                state_nxt = ST_VEC_HI;
            end
        endcase
        if (rst_hold) begin
            state_nxt  = ST_VEC_HI;
            pc_nxt     = 16'h0000;
            sp_nxt     = `RSCPU_SP_RST;
            mem_re_out = 1'b0;
            mem_we_out = 1'b0;
        end
    end

    always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            state_r  <= ST_VEC_HI;
            pc_r     <= 16'h0000;
            sp_r     <= `RSCPU_SP_RST;
            ret_r    <= 16'h0000;
            target_r <= 16'h0000;
        end else begin
            state_r  <= state_nxt;
            pc_r     <= pc_nxt;
            sp_r     <= sp_nxt;
            ret_r    <= ret_nxt;
            target_r <= target_nxt;
        end
    end

    assign pc_out       = pc_r;
    assign sp_out       = sp_r;
    assign index_hi_out = `RSCPU_HX_HI_RST;
    assign ccr_out      = `RSCPU_CCR_RST;
    assign cpu_run_out  = (state_r == ST_RUN) && !rst_hold;
    assign busy_out     = !cpu_run_out;

    ////////////////////////////////////////////////////////////////////////////
    // Assertions
    default clocking cb @(posedge ref_clk_in); endclocking
    default disable iff (!arst_n_in);

    sequence vec_fetch_s;
        mem_re_out && mem_addr_out == `RSCPU_VEC_HI_ADDR ##1
        mem_re_out && mem_addr_out == `RSCPU_VEC_LO_ADDR;
    endsequence

    sequence push_s;
        mem_we_out && mem_addr_out == $past(sp_r) && mem_wdata_out == ret_r[7:0] ##1
        mem_we_out && mem_wdata_out == ret_r[15:8];
    endsequence

    AST_SRC_RESET: assert property (watchdog_timeout_in || illegal_addr_in |=> sys_reset_out [*8])
        else $error("source did not hold reset");
    AST_STOP_ILLEGAL_OPCODE_FLAG: assert property (cpu_run_out && stop_instr_in && !stop_enable_in
        |=> sys_reset_out && cause_r[`RSCPU_BIT_ILLEGAL_OPCODE_FLAG] && !stop_mode_out)
        else $error("disabled stop did not reset");
    AST_ILLEGAL_OPCODE_FLAG_FLAG: assert property (illegal_opcode_in && !watchdog_timeout_in && !illegal_addr_in
        && !pin_low |=> reset_cause_status_out == 8'h10)
        else $error("illegal opcode flag missing");
    AST_POR_FLAG: assert property ($rose(arst_n_in) |-> reset_cause_status_out == `RSCPU_CAUSE_POR)
        else $error("power-on flag missing");
    AST_ONE_WRITE: assert property (lock_r && !rst_hold && clk_sel_wr_in |=> $stable(xtal_req_r))
        else $error("second clock select write taken");
    AST_IRC_RESET: assert property (sys_reset_out |=> !bus_clk_sel_out && !clk_sel_locked_out)
        else $error("clock not on internal oscillator after reset");
    AST_VECTOR: assert property ($fell(rst_hold) |-> vec_fetch_s ##2
        cpu_run_out && pc_out == {$past(mem_rdata_in, 2), $past(mem_rdata_in, 1)})
        else $error("reset vector not loaded");
    AST_REG_RST: assert property (sys_reset_out |=> sp_out == `RSCPU_SP_RST &&
        index_hi_out == 8'h00 && ccr_out[6] && ccr_out[5] && ccr_out[3])
        else $error("CPU register reset value wrong");
    AST_PERIPH: assert property (trig |=> periph_reset_out && busy_out)
        else $error("peripherals not reset");
    AST_XTAL_WAIT: assert property ($rose(bus_clk_sel_out) |-> $past(stab_cnt_r) == STAB_MAX)
        else $error("crystal selected before settling");
    AST_FLASH: assert property (flash_prog_en_out |-> flash_prog_req_in && !sys_reset_out &&
        (bus_clk_sel_out ? BUS_HZ_XTAL : BUS_HZ_IRC) >= `RSCPU_FLASH_MIN_HZ)
        else $error("flash enabled on slow bus");
    AST_CALL: assert property (cpu_run_out && call_subroutine_instr_in && !trig
        |=> (push_s ##1 pc_out == target_r) or (sys_reset_out [*1]))
        else $error("call did not push return address");
    AST_RETURN: assert property (cpu_run_out && return_instr_in && !call_subroutine_instr_in && !trig
        ##1 !rst_hold [*3] |-> ##1 pc_out == {$past(mem_rdata_in, 2), $past(mem_rdata_in, 1)})
        else $error("return did not restore program counter");
    AST_LATEST: assert property (watchdog_timeout_in && !illegal_opcode_in && !illegal_addr_in
        && !pin_low && !stop_instr_in |=> reset_cause_status_out == 8'h20)
        else $error("cause flags not latest only");

endmodule : rscpu_reset

/* File: sim/tb_reset_source_and_cpu_reset_state.sv */
// Self-checking bench for the reset source and CPU reset state block.
// Assumes rscpu_reset with a short crystal settle count; memory modelled here, read latency 1.
module tb_reset_source_and_cpu_reset_state;
    timeunit 1ns;
    timeprecision 100ps;
    localparam int STAB = 6;
    logic        ref_clk_in = 0, arst_n_in = 0, illegal_opcode_in = 0, illegal_addr_in = 0;
    logic        watchdog_timeout_in = 0, ext_reset_n_in = 1, stop_instr_in = 0, stop_enable_in = 0;
    logic        clk_sel_wr_in = 0, clk_sel_xtal_in = 0, xtal_clk_in = 0, flash_prog_req_in = 0;
    logic        call_subroutine_instr_in = 0, return_instr_in = 0;
    logic [15:0] ret_addr_in = 16'h0000, target_in = 16'h0000, mem_addr_out, pc_out, sp_out;
    logic [7:0]  mem_rdata_in = 8'h00, mem_wdata_out, reset_cause_status_out, index_hi_out, ccr_out;
    logic        mem_re_out, mem_we_out, sys_reset_out, periph_reset_out, stop_mode_out;
    logic        bus_clk_sel_out, clk_sel_locked_out, flash_prog_en_out, cpu_run_out, busy_out;
    logic [7:0]  mem [0:65535];
    logic        xtal_run = 0;
    logic [1:0]  xtal_div = 2'h0;
    int          xtal_rises = 0, err_total = 0, samples_checked = 0;

    rscpu_reset #(.XTAL_STAB_CYC(STAB)) rscpu_reset_inst (
        .ref_clk_in(ref_clk_in), .arst_n_in(arst_n_in), .illegal_opcode_in(illegal_opcode_in),
        .illegal_addr_in(illegal_addr_in), .watchdog_timeout_in(watchdog_timeout_in),
        .ext_reset_n_in(ext_reset_n_in), .stop_instr_in(stop_instr_in), .stop_enable_in(stop_enable_in),
        .clk_sel_wr_in(clk_sel_wr_in), .clk_sel_xtal_in(clk_sel_xtal_in), .xtal_clk_in(xtal_clk_in),
        .flash_prog_req_in(flash_prog_req_in), .call_subroutine_instr_in(call_subroutine_instr_in),
        .return_instr_in(return_instr_in), .ret_addr_in(ret_addr_in), .target_in(target_in),
        .mem_rdata_in(mem_rdata_in), .mem_addr_out(mem_addr_out), .mem_wdata_out(mem_wdata_out),
        .mem_re_out(mem_re_out), .mem_we_out(mem_we_out), .reset_cause_status_out(reset_cause_status_out),
        .sys_reset_out(sys_reset_out), .periph_reset_out(periph_reset_out), .stop_mode_out(stop_mode_out),
        .bus_clk_sel_out(bus_clk_sel_out), .clk_sel_locked_out(clk_sel_locked_out),
        .flash_prog_en_out(flash_prog_en_out), .pc_out(pc_out), .sp_out(sp_out),
        .index_hi_out(index_hi_out), .ccr_out(ccr_out), .cpu_run_out(cpu_run_out), .busy_out(busy_out));

    always #2.5 ref_clk_in = ~ref_clk_in;

    ////////////////////////////////////////////////////////////////////////////
    // Memory: data one cycle after a read, scrambled when not read
    always @(posedge ref_clk_in) begin
        mem_rdata_in <= mem_re_out ? mem[mem_addr_out] : ~mem_rdata_in;
        if (mem_we_out) mem[mem_addr_out] <= mem_wdata_out;
    end

    // Crystal: rising edge every 8 cycles while enabled
    always @(posedge ref_clk_in) begin
        if (xtal_run) begin
            xtal_div <= xtal_div + 2'h1;
            if (xtal_div == 2'h3) begin
                xtal_clk_in <= ~xtal_clk_in;
                if (!xtal_clk_in) xtal_rises <= xtal_rises + 1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            err_total++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic stop_test;
        $display("checks %0d mismatches %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask : stop_test

    task automatic wait_run(input int max);
        int i;
        for (i = 0; i < max; i++) begin
            @(posedge ref_clk_in);
            #1;
            if (cpu_run_out === 1'b1) break;
        end
        check({15'h0, cpu_run_out}, 16'h0001);
    endtask : wait_run

    // Reset state after a restart; vector at top locations is C012
    task automatic check_restart(input logic [7:0] cause);
        wait_run(80);
        check({8'h0, reset_cause_status_out}, {8'h0, cause});
        check(pc_out, 16'hC012);
        check(sp_out, 16'h00FF);
        check({8'h0, index_hi_out}, 16'h0000);
        check({8'h0, ccr_out & 8'h68}, 16'h0068);
        check({15'h0, periph_reset_out}, 16'h0000);
        check({15'h0, busy_out}, 16'h0000);
        check({15'h0, bus_clk_sel_out}, 16'h0000);
        check({15'h0, clk_sel_locked_out}, 16'h0000);
    endtask : check_restart

    task automatic t_power_on;
        repeat (10) @(posedge ref_clk_in);
        #1;
        check({8'h0, reset_cause_status_out}, 16'h0080);
        check({15'h0, periph_reset_out}, 16'h0001);
        @(posedge ref_clk_in);
        arst_n_in <= 1'b1;
        check_restart(8'h80);
        @(posedge ref_clk_in);
        flash_prog_req_in <= 1'b1;
        #1;
        check({15'h0, flash_prog_en_out}, 16'h0001);
    endtask : t_power_on

    task automatic t_call_return;
        @(posedge ref_clk_in);
        call_subroutine_instr_in <= 1'b1;
        ret_addr_in              <= 16'h1234;
        target_in                <= 16'h4000;
        @(posedge ref_clk_in);
        call_subroutine_instr_in <= 1'b0;
        wait_run(20);
        check(pc_out, 16'h4000);
        check(sp_out, 16'h00FD);
        check({8'h0, mem[16'h00FF]}, 16'h0034);
        check({8'h0, mem[16'h00FE]}, 16'h0012);
        @(posedge ref_clk_in);
        return_instr_in <= 1'b1;
        @(posedge ref_clk_in);
        return_instr_in <= 1'b0;
        wait_run(20);
        check(pc_out, 16'h1234);
        check(sp_out, 16'h00FF);
    endtask : t_call_return

    task automatic t_clock_select;
        int i;
        @(posedge ref_clk_in);
        clk_sel_wr_in   <= 1'b1;
        clk_sel_xtal_in <= 1'b1;
        @(posedge ref_clk_in);
        clk_sel_wr_in <= 1'b0;
        xtal_run      <= 1'b1;
        #1;
        check({15'h0, clk_sel_locked_out}, 16'h0001);
        check({15'h0, bus_clk_sel_out}, 16'h0000);
        for (i = 0; i < 8 * STAB + 60; i++) begin
            @(posedge ref_clk_in);
            #1;
            if (bus_clk_sel_out === 1'b1) break;
        end
        check({15'h0, bus_clk_sel_out}, 16'h0001);
        check({15'h0, (xtal_rises >= STAB) ? 1'b1 : 1'b0}, 16'h1);
        check({15'h0, flash_prog_en_out}, 16'h0000);
        @(posedge ref_clk_in);
        clk_sel_wr_in   <= 1'b1;
        clk_sel_xtal_in <= 1'b0;
        @(posedge ref_clk_in);
        clk_sel_wr_in <= 1'b0;
        repeat (3) @(posedge ref_clk_in);
        #1;
        check({15'h0, bus_clk_sel_out}, 16'h0001);
    endtask : t_clock_select

    // One trigger; bits: 0 watchdog, 1 illegal address, 2 illegal opcode, 3 stop, 4 pin
    task automatic trigger(input logic [4:0] src, input logic [7:0] cause);
        @(posedge ref_clk_in);
        watchdog_timeout_in <= src[0];
        illegal_addr_in     <= src[1];
        illegal_opcode_in   <= src[2];
        stop_instr_in       <= src[3];
        ext_reset_n_in      <= ~src[4];
        @(posedge ref_clk_in);
        {watchdog_timeout_in, illegal_addr_in, illegal_opcode_in, stop_instr_in} <= 4'h0;
        @(posedge ref_clk_in);
        ext_reset_n_in <= 1'b1;
        repeat (2) @(posedge ref_clk_in);
        #1;
        check({15'h0, sys_reset_out}, 16'h0001);
        check({15'h0, periph_reset_out}, 16'h0001);
        check({15'h0, busy_out}, 16'h0001);
        check_restart(cause);
    endtask : trigger

    task automatic t_sources;
        logic [4:0] srcs [6];
        logic [7:0] causes [6];
        int         i;
        srcs   = '{5'h01, 5'h02, 5'h04, 5'h08, 5'h10, 5'h03};
        causes = '{8'h20, 8'h08, 8'h10, 8'h10, 8'h40, 8'h28};
        stop_enable_in <= 1'b0;
        for (i = 0; i < 6; i++) trigger(srcs[i], causes[i]);
        check({15'h0, flash_prog_en_out}, 16'h0001);
    endtask : t_sources

    task automatic t_stop_enabled;
        @(posedge ref_clk_in);
        stop_enable_in <= 1'b1;
        stop_instr_in  <= 1'b1;
        #1;
        check({15'h0, stop_mode_out}, 16'h0001);
        @(posedge ref_clk_in);
        stop_instr_in <= 1'b0;
        repeat (3) @(posedge ref_clk_in);
        #1;
        check({15'h0, sys_reset_out}, 16'h0000);
        check({8'h0, reset_cause_status_out}, 16'h0028);
    endtask : t_stop_enabled

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        mem[16'hFFFE] = 8'hC0;
        mem[16'hFFFF] = 8'h12;
        t_power_on();
        t_call_return();
        t_clock_select();
        t_sources();
        t_stop_enabled();
        stop_test();
    end

    initial begin
        repeat (20000) @(posedge ref_clk_in);
        err_total++;
        stop_test();
    end
endmodule : tb_reset_source_and_cpu_reset_state
